// >>> rtl/tcc_channel.sv
// One channel: capture-edge detection and compare-output pin level
`timescale 1ns/1ps
module tcc_channel (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire tcc_pkg::tcc_chcfg_t cfg,
	input wire logic pinIn,
	input wire logic matchEvt,
	output logic captureEvt,
	output logic pinOut,
	output logic pinOe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic prevPin; // Pin level one cycle ago
		logic level; // Compare output level
		logic oe; // Drive enable
	} tcc_ch_state_t;

	tcc_ch_state_t s;
	tcc_ch_state_t next_s;
	logic rise; // Rising edge this cycle
	logic fall; // Falling edge this cycle

	// Edge select and output action
	always_comb begin
		next_s = s;
		rise = pinIn && !s.prevPin;
		fall = !pinIn && s.prevPin;
		next_s.prevPin = pinIn;
		next_s.oe = !cfg.funcSelect;
		// Capture edge from the same two-bit field
		if (!cfg.funcSelect) begin
			captureEvt = 1'b0;
		end else if (cfg.action[1]) begin
			captureEvt = rise || fall;
		end else if (cfg.action[0]) begin
			captureEvt = fall;
		end else begin
			captureEvt = rise;
		end
		// Already-at-level pins simply keep their value
		if (matchEvt && !cfg.funcSelect) begin
			case (cfg.action)
				tcc_pkg::ACT_LOW: next_s.level = 1'b0;
				tcc_pkg::ACT_HIGH: next_s.level = 1'b1;
				tcc_pkg::ACT_TOGGLE: next_s.level = !s.level;
				default: next_s.level = s.level;
			endcase
		end
	end

	// Register the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pinOut = s.level;
	assign pinOe = s.oe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_toggle;
		@(posedge sys_clk) disable iff (!rstn)
		matchEvt && !cfg.funcSelect && cfg.action == tcc_pkg::ACT_TOGGLE
		|=> pinOut != $past(pinOut);
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle");

	property p_drive;
		@(posedge sys_clk) disable iff (!rstn)
		matchEvt && !cfg.funcSelect && cfg.action == tcc_pkg::ACT_HIGH
		|=> pinOut;
	endproperty
	a_drive: assert property (p_drive) else $error("pin not high");

	property p_fall;
		@(posedge sys_clk) disable iff (!rstn)
		cfg.funcSelect && cfg.action == tcc_pkg::ACT_LOW && $fell(pinIn)
		|-> captureEvt;
	endproperty
	a_fall: assert property (p_fall) else $error("fall missed");

endmodule

// >>> rtl/tcc_pkg.sv
// Constants, register map and carrier types of the capture/compare timer
package tcc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_MODE = 8'h00; // Timer mode register
	localparam logic [7:0] OFF_CTRL = 8'h04; // Timer control register
	localparam logic [7:0] OFF_IRQEN = 8'h08; // Irq enable register
	localparam logic [7:0] OFF_STATUS = 8'h0C; // Timer status register
	localparam logic [7:0] OFF_PFC_AB = 8'h10; // Pin function ctrl A/B
	localparam logic [7:0] OFF_PFC_CD = 8'h14; // Pin function ctrl C/D
	localparam logic [7:0] OFF_COUNTER = 8'h18; // Up counter
	localparam logic [7:0] OFF_GR_A = 8'h1C; // First general register
	localparam logic [7:0] OFF_GR_B = 8'h20; // Second general register
	localparam logic [7:0] OFF_GR_C = 8'h24; // Third, may buffer A
	localparam logic [7:0] OFF_GR_D = 8'h28; // Fourth, may buffer B

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_START = 0; // Counter runs when set
	localparam int MODE_BUF_A = 1; // General reg C buffers A
	localparam int MODE_BUF_B = 2; // General reg D buffers B
	localparam int CTRL_CLEAR_A = 7; // Clear counter on match A
	localparam int CTRL_CKS_LSB = 0; // Three-bit clock select
	localparam int IRQEN_OVF = 7; // Overflow irq enable
	localparam int STATUS_OVF = 7; // Overflow flag
	localparam int PFC_HI_LSB = 4; // Channel B or D field
	localparam int PFC_LO_LSB = 0; // Channel A or C field

	// ------------------------------------------------------------
	// Reset values and fixed read patterns
	// ------------------------------------------------------------
	localparam logic [15:0] COUNTER_RESET = 16'h0000; // Counter at reset
	localparam logic [15:0] COUNTER_TOP = 16'hFFFF; // Last count
	localparam logic [15:0] GR_RESET = 16'hFFFF; // General regs at reset
	localparam logic [7:0] PFC_RESERVED = 8'h88; // Bits 7 and 3 read 1
	localparam logic [7:0] PFC_WRITABLE = 8'h77; // Storable pfc bits
	localparam logic [7:0] STATUS_RESERVED = 8'h70; // Bits 6..4 read 1
	localparam logic [6:0] DIV_RESET = 7'h00; // Prescaler start

	// ------------------------------------------------------------
	// Output-action / capture-edge codes
	// ------------------------------------------------------------
	localparam logic [1:0] ACT_NONE = 2'h0; // Pin unchanged / rising
	localparam logic [1:0] ACT_LOW = 2'h1; // Drive 0 / falling
	localparam logic [1:0] ACT_HIGH = 2'h2; // Drive 1 / both edges
	localparam logic [1:0] ACT_TOGGLE = 2'h3; // Toggle / both edges

	// Per-channel configuration carried into a channel
	typedef struct packed {
		logic funcSelect; // 0 compare, 1 capture
		logic [1:0] action; // Action or edge code
	} tcc_chcfg_t;

endpackage

// >>> rtl/tcc_prescaler.sv
// Count-clock divider: one-cycle enable at sys_clk / 2^select
`timescale 1ns/1ps
module tcc_prescaler (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [2:0] clockSelect,
	output logic countTick
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [6:0] div; // Free-running divider
		logic tick; // Registered enable
	} tcc_pre_state_t;

	tcc_pre_state_t s;
	tcc_pre_state_t next_s;
	logic [6:0] mask; // Low divider bits that must be all ones

	// Next divider and tick
	always_comb begin
		next_s = s;
		mask = 7'((8'h01 << clockSelect) - 8'h01);
		next_s.div = s.div + 7'h01;
		next_s.tick = ((s.div & mask) == mask);
	end

	// Register the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign countTick = s.tick;

endmodule

// >>> rtl/tcc_timer.sv
// Four-channel capture/compare timer with AHB-Lite register slave
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module tcc_timer (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [3:0] pinIn,
	output logic [3:0] pinOut,
	output logic [3:0] pinOe,
	output logic irqReq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] counter; // Up counter
		logic [3:0][15:0] gr; // General registers A..D
		logic [7:0] pfcAb; // Pin function A/B, writable bits
		logic [7:0] pfcCd; // Pin function C/D, writable bits
		logic start; // Counter running
		logic [1:0] bufEn; // Buffer enables for A, B
		logic [2:0] cks; // Count clock select
		logic clearOnA; // Periodic mode
		logic ovfIe; // Overflow irq enable
		logic [3:0] imIe; // Match/capture irq enables
		logic ovf; // Overflow flag
		logic [3:0] imf; // Match/capture flags
		logic armOvf; // Overflow flag read as one
		logic [3:0] armImf; // Channel flags read as one
		logic wrPending; // Write data phase active
		logic [7:0] wrAddr; // Latched write offset
		logic [31:0] rdata; // Read data
		logic ready; // Bus ready
		logic irq; // Interrupt request
	} tcc_state_t;

	tcc_state_t s;
	tcc_state_t next_s;
	logic countTick; // Count-clock enable
	logic tick; // Enable while counter runs
	logic addrPhase; // Accepted address phase
	logic [3:0] matchEvt; // Compare match events
	logic [3:0] capRaw; // Capture edges from channels
	logic [3:0] capEvt; // Effective capture events
	logic [3:0] asBuffer; // Channel acts as buffer only
	tcc_pkg::tcc_chcfg_t [3:0] cfg; // Channel configurations
	logic clearNow; // Counter clears this tick

	// Pfc readback with the fixed ones
	function automatic logic [7:0] pfcRead(input logic [7:0] v);
		pfcRead = v | tcc_pkg::PFC_RESERVED;
	endfunction

	// Channel field from a pin-function register
	function automatic tcc_pkg::tcc_chcfg_t pfcField(
		input logic [7:0] v, input logic hi);
		pfcField = hi ? v[tcc_pkg::PFC_HI_LSB +: 3] :
			v[tcc_pkg::PFC_LO_LSB +: 3];
	endfunction

	// ------------------------------------------------------------
	// Count clock and channels
	// ------------------------------------------------------------
	tcc_prescaler u_pre (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clockSelect(s.cks),
		.countTick(countTick)
	);

	assign cfg[0] = pfcField(s.pfcAb, 1'b0);
	assign cfg[1] = pfcField(s.pfcAb, 1'b1);
	assign cfg[2] = pfcField(s.pfcCd, 1'b0);
	assign cfg[3] = pfcField(s.pfcCd, 1'b1);
	assign asBuffer = {s.bufEn, 2'b00};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			// Buffer registers neither match nor capture on their own
			tcc_channel u_ch (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.cfg(cfg[gi]),
				.pinIn(pinIn[gi]),
				.matchEvt(matchEvt[gi]),
				.captureEvt(capRaw[gi]),
				.pinOut(pinOut[gi]),
				.pinOe(pinOe[gi])
			);
			// Match only on the tick leaving the equal count
			assign matchEvt[gi] = tick && !cfg[gi].funcSelect &&
				!asBuffer[gi] && (s.counter == s.gr[gi]);
			assign capEvt[gi] = capRaw[gi] && !asBuffer[gi];
		end
	endgenerate

	assign tick = countTick && s.start;
	assign addrPhase = hsel && hready && htrans[1];
	assign clearNow = matchEvt[0] && s.clearOnA;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		// Bus address phase: latch writes, read data ready next cycle
		next_s.wrPending = addrPhase && hwrite;
		if (addrPhase) begin
			next_s.wrAddr = haddr[7:0];
		end
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				tcc_pkg::OFF_MODE:
					next_s.rdata = {29'h0, s.bufEn, s.start};
				tcc_pkg::OFF_CTRL:
					next_s.rdata = {24'h0, s.clearOnA, 4'h0, s.cks};
				tcc_pkg::OFF_IRQEN:
					next_s.rdata = {24'h0, s.ovfIe, 3'h0, s.imIe};
				tcc_pkg::OFF_STATUS: begin
					next_s.rdata = {24'h0, s.ovf, 3'h0, s.imf} |
						{24'h0, tcc_pkg::STATUS_RESERVED};
					// Reading a one arms its clear
					next_s.armOvf = s.armOvf || s.ovf;
					next_s.armImf = s.armImf | s.imf;
				end
				tcc_pkg::OFF_PFC_AB: next_s.rdata = {24'h0, pfcRead(s.pfcAb)};
				tcc_pkg::OFF_PFC_CD: next_s.rdata = {24'h0, pfcRead(s.pfcCd)};
				tcc_pkg::OFF_COUNTER: next_s.rdata = {16'h0, s.counter};
				tcc_pkg::OFF_GR_A: next_s.rdata = {16'h0, s.gr[0]};
				tcc_pkg::OFF_GR_B: next_s.rdata = {16'h0, s.gr[1]};
				tcc_pkg::OFF_GR_C: next_s.rdata = {16'h0, s.gr[2]};
				tcc_pkg::OFF_GR_D: next_s.rdata = {16'h0, s.gr[3]};
				default: next_s.rdata = 32'h0;
			endcase
		end
		// Counter runs; clear on A takes precedence over increment
		if (tick) begin
			if (clearNow) begin
				next_s.counter = tcc_pkg::COUNTER_RESET;
			end else begin
				next_s.counter = s.counter + 16'h0001;
			end
		end
		// Write data phase; hardware events below win over it
		if (s.wrPending) begin
			case (s.wrAddr)
				tcc_pkg::OFF_MODE: begin
					next_s.start = hwdata[tcc_pkg::MODE_START];
					next_s.bufEn = {hwdata[tcc_pkg::MODE_BUF_B],
						hwdata[tcc_pkg::MODE_BUF_A]};
				end
				tcc_pkg::OFF_CTRL: begin
					next_s.clearOnA = hwdata[tcc_pkg::CTRL_CLEAR_A];
					next_s.cks = hwdata[tcc_pkg::CTRL_CKS_LSB +: 3];
				end
				tcc_pkg::OFF_IRQEN: begin
					next_s.ovfIe = hwdata[tcc_pkg::IRQEN_OVF];
					next_s.imIe = hwdata[3:0];
				end
				tcc_pkg::OFF_STATUS: begin
					// Only armed flags written as zero clear
					if (s.armOvf && !hwdata[tcc_pkg::STATUS_OVF]) begin
						next_s.ovf = 1'b0;
					end
					next_s.imf = s.imf & ~(s.armImf & ~hwdata[3:0]);
					next_s.armOvf = 1'b0;
					next_s.armImf = 4'h0;
				end
				tcc_pkg::OFF_PFC_AB:
					next_s.pfcAb = hwdata[7:0] & tcc_pkg::PFC_WRITABLE;
				tcc_pkg::OFF_PFC_CD:
					next_s.pfcCd = hwdata[7:0] & tcc_pkg::PFC_WRITABLE;
				// Whole-word accesses are assumed for these
				tcc_pkg::OFF_COUNTER: next_s.counter = hwdata[15:0];
				tcc_pkg::OFF_GR_A: next_s.gr[0] = hwdata[15:0];
				tcc_pkg::OFF_GR_B: next_s.gr[1] = hwdata[15:0];
				tcc_pkg::OFF_GR_C: next_s.gr[2] = hwdata[15:0];
				tcc_pkg::OFF_GR_D: next_s.gr[3] = hwdata[15:0];
				default: next_s.start = s.start;
			endcase
		end
		// Overflow: wrap from the top count to zero
		if (tick && !clearNow && s.counter == tcc_pkg::COUNTER_TOP) begin
			next_s.ovf = 1'b1;
		end
		// Compare matches and captures per channel
		for (int i = 0; i < 4; i++) begin
			if (matchEvt[i] || capEvt[i]) begin
				next_s.imf[i] = 1'b1;
			end
			if (capEvt[i]) begin
				next_s.gr[i] = s.counter;
			end
		end
		// Buffer transfers for A (via C) and B (via D)
		for (int i = 0; i < 2; i++) begin
			if (s.bufEn[i] && matchEvt[i]) begin
				next_s.gr[i] = s.gr[i + 2];
			end
			if (s.bufEn[i] && capEvt[i]) begin
				next_s.gr[i + 2] = s.gr[i];
			end
		end
		// Interrupt request from enabled flags
		next_s.irq = (s.ovf && s.ovfIe) ||
			(|(s.imf & s.imIe));
		next_s.ready = 1'b1;
	end

	// Register the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.counter <= tcc_pkg::COUNTER_RESET;
			s.gr <= {4{tcc_pkg::GR_RESET}};
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Zero-wait slave, always OKAY
	assign hreadyout = s.ready;
	assign hrdata = s.rdata;
	assign hresp = 1'b0;
	assign irqReq = s.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_rd_pfc;
		addrPhase && !hwrite && (haddr[7:0] == tcc_pkg::OFF_PFC_AB ||
			haddr[7:0] == tcc_pkg::OFF_PFC_CD);
	endsequence
	property p_resvd;
		@(posedge sys_clk) disable iff (!rstn)
		s_rd_pfc |=> hrdata[7] && hrdata[3];
	endproperty
	a_resvd: assert property (p_resvd) else $error("pfc rsvd");

	property p_clear;
		@(posedge sys_clk) disable iff (!rstn)
		tick && matchEvt[0] && s.clearOnA && !s.wrPending
		|=> s.counter == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");

	property p_ovf;
		@(posedge sys_clk) disable iff (!rstn)
		tick && !clearNow && s.counter == 16'hFFFF
		|=> s.ovf && s.counter == 16'h0000;
	endproperty
	a_ovf: assert property (p_ovf) else $error("ovf missed");

	property p_irq;
		@(posedge sys_clk) disable iff (!rstn)
		(s.ovf && s.ovfIe) || |(s.imf & s.imIe) |=> irqReq;
	endproperty
	a_irq: assert property (p_irq) else $error("no irq");

	property p_match_flag;
		@(posedge sys_clk) disable iff (!rstn)
		matchEvt[1] |=> s.imf[1] ##1 irqReq || !s.imIe[1];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("imf");

	property p_match_late;
		@(posedge sys_clk) disable iff (!rstn)
		!tick |-> matchEvt == 4'h0;
	endproperty
	a_match_late: assert property (p_match_late) else $error("early");

	property p_capture;
		@(posedge sys_clk) disable iff (!rstn)
		capEvt[2] |=> s.gr[2] == $past(s.counter) && s.imf[2];
	endproperty
	a_capture: assert property (p_capture) else $error("capture");

	sequence s_bufcap_a;
		capEvt[0] && s.bufEn[0];
	endsequence
	property p_bufcap;
		@(posedge sys_clk) disable iff (!rstn)
		s_bufcap_a |=> s.gr[2] == $past(s.gr[0]) &&
			s.gr[0] == $past(s.counter);
	endproperty
	a_bufcap: assert property (p_bufcap) else $error("buf cap");

	property p_bufcmp;
		@(posedge sys_clk) disable iff (!rstn)
		matchEvt[0] && s.bufEn[0] |=> s.gr[0] == $past(s.gr[2]);
	endproperty
	a_bufcmp: assert property (p_bufcmp) else $error("buf cmp");

endmodule

// >>> sim/tcc_pin_model.sv
// Far-side model of the four timer pins: external drivers on the wires
`timescale 1ns/1ps
module tcc_pin_model (
	input wire logic [3:0] pinOut,
	input wire logic [3:0] pinOe,
	input wire logic [3:0] levelReq,
	output logic [3:0] pinWire
);
	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// Timer wins where it drives, so the outside source never fights it
	assign pinWire = (pinOe & pinOut) | (~pinOe & levelReq);
endmodule

// >>> sim/tcc_timer_bench.sv
// Self-checking bench of the four-channel capture/compare timer
`timescale 1ns/1ps
module tcc_timer_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic sys_clk; // 100 MHz system clock
	logic rstn; // Active-low reset
	logic hsel, hwrite, hready, hreadyout, hresp, irqReq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0] pinWire, pinOut, pinOe, levelReq;
	int mismatches; // Failed comparisons
	int cmpCount; // All comparisons
	int cycles; // Cycle count for the hang guard
	logic [31:0] q, oldA;

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	tcc_timer DUT (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .pinIn(pinWire),
		.pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
	tcc_pin_model pins (.pinOut(pinOut), .pinOe(pinOe),
		.levelReq(levelReq), .pinWire(pinWire));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Whole run is a few hundred cycles; generous ceiling
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (mismatches == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One whole-word single transfer; waits on ready, no cycle count assumed
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h00000000;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h00000000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h00000000, d);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Read arms every set flag, then a zero write clears them
	task automatic clear_flags();
		rd(tcc_pkg::OFF_STATUS, q);
		wr(tcc_pkg::OFF_STATUS, 32'h00000000);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset state of counter, general registers, pin control and pins
	task automatic sc_reset();
		rd(tcc_pkg::OFF_COUNTER, q);
		check("counter", q, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			rd(tcc_pkg::OFF_GR_A + 8'(4 * i), q);
			check("general reg", q, 32'h0000FFFF);
		end
		rd(tcc_pkg::OFF_PFC_AB, q);
		check("pfc ab", q, 32'h00000088);
		check("pin out", {28'h0000000, pinOut}, 32'h00000000);
	endtask

	// A toggles, B drives 0 on a low pin, C drives 1, D does nothing
	task automatic sc_compare();
		for (int i = 0; i < 4; i++) begin
			wr(tcc_pkg::OFF_GR_A + 8'(4 * i), 32'h00000005);
		end
		wr(tcc_pkg::OFF_PFC_AB, 32'h00000013);
		wr(tcc_pkg::OFF_PFC_CD, 32'h00000002);
		wr(tcc_pkg::OFF_IRQEN, 32'h0000000F);
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		idle(20);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		check("pin out", {28'h0000000, pinOut}, 32'h00000005);
		check("pin oe", {28'h0000000, pinOe}, 32'h0000000F);
		rd(tcc_pkg::OFF_STATUS, q);
		check("status", q, 32'h0000007F);
		check("irq", {31'h0, irqReq}, 32'h00000001);
		wr(tcc_pkg::OFF_STATUS, 32'h00000000);
		idle(2);
		rd(tcc_pkg::OFF_STATUS, q);
		check("status", q, 32'h00000070);
		check("irq", {31'h0, irqReq}, 32'h00000000);
	endtask

	// Wrap sets overflow; an unarmed zero write leaves it standing
	task automatic sc_overflow();
		wr(tcc_pkg::OFF_IRQEN, 32'h00000080);
		wr(tcc_pkg::OFF_COUNTER, 32'h00001234);
		rd(tcc_pkg::OFF_COUNTER, q);
		check("counter", q, 32'h00001234);
		wr(tcc_pkg::OFF_COUNTER, 32'h0000FFFD);
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		idle(8);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		wr(tcc_pkg::OFF_STATUS, 32'h00000000);
		idle(2);
		rd(tcc_pkg::OFF_STATUS, q);
		check("overflow", q & 32'h00000080, 32'h00000080);
		check("irq", {31'h0, irqReq}, 32'h00000001);
		clear_flags();
		idle(2);
		rd(tcc_pkg::OFF_STATUS, q);
		check("overflow", q & 32'h00000080, 32'h00000000);
		check("irq", {31'h0, irqReq}, 32'h00000000);
	endtask

	// Clear on match A keeps the counter within 0..5
	task automatic sc_clear_on_a();
		wr(tcc_pkg::OFF_COUNTER, 32'h00000000);
		wr(tcc_pkg::OFF_PFC_AB, 32'h00000000);
		wr(tcc_pkg::OFF_CTRL, 32'h00000080);
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		for (int i = 0; i < 8; i++) begin
			rd(tcc_pkg::OFF_COUNTER, q);
			check("count bound", {31'h0, q <= 32'h5}, 32'h1);
		end
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		wr(tcc_pkg::OFF_CTRL, 32'h00000000);
	endtask

	// Capture: A rising, B falling, C both; then buffered capture on A
	task automatic sc_capture();
		clear_flags();
		// Only channel A may raise the request here
		wr(tcc_pkg::OFF_IRQEN, 32'h00000001);
		wr(tcc_pkg::OFF_COUNTER, 32'h00000100);
		wr(tcc_pkg::OFF_PFC_AB, 32'h00000054);
		wr(tcc_pkg::OFF_PFC_CD, 32'h00000006);
		rd(tcc_pkg::OFF_PFC_AB, q);
		check("pfc ab", q, 32'h000000DC);
		rd(tcc_pkg::OFF_PFC_CD, q);
		check("pfc cd", q, 32'h0000008E);
		check("pin oe", {28'h0000000, pinOe}, 32'h00000008);
		// Edge lands with the start; first tick still sees 0x100
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		levelReq <= 4'b0111;
		idle(4);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		rd(tcc_pkg::OFF_STATUS, q);
		check("flags", q & 32'h0000000F, 32'h00000005);
		check("irq", {31'h0, irqReq}, 32'h00000001);
		rd(tcc_pkg::OFF_GR_B, q);
		check("reg b", q, 32'h00000005);
		rd(tcc_pkg::OFF_GR_A, oldA);
		check("reg a", oldA, 32'h00000100);
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		levelReq <= 4'b0101;
		idle(4);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		rd(tcc_pkg::OFF_STATUS, q);
		check("flags", q & 32'h0000000F, 32'h00000007);
		wr(tcc_pkg::OFF_MODE, 32'h00000003);
		levelReq <= 4'b0100;
		idle(4);
		levelReq <= 4'b0101;
		idle(4);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		rd(tcc_pkg::OFF_GR_C, q);
		check("buffer c", q, oldA);
		rd(tcc_pkg::OFF_GR_A, q);
		check("reg a", {31'h0, q > oldA}, 32'h1);
	endtask

	// Buffered compare: match A reloads A from C; 7 ticks counted
	task automatic sc_buffered_compare();
		wr(tcc_pkg::OFF_PFC_AB, 32'h00000000);
		wr(tcc_pkg::OFF_COUNTER, 32'h00000000);
		wr(tcc_pkg::OFF_GR_A, 32'h00000002);
		wr(tcc_pkg::OFF_GR_C, 32'h00000040);
		wr(tcc_pkg::OFF_MODE, 32'h00000003);
		idle(4);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		rd(tcc_pkg::OFF_GR_A, q);
		check("reg a", q, 32'h00000040);
		rd(tcc_pkg::OFF_GR_C, q);
		check("buffer c", q, 32'h00000040);
		rd(tcc_pkg::OFF_COUNTER, q);
		check("counter", q, 32'h00000007);
	endtask

	// Select 2 ticks every 4 clocks: 16 running clocks give 4 counts
	task automatic sc_prescale();
		wr(tcc_pkg::OFF_CTRL, 32'h00000002);
		wr(tcc_pkg::OFF_COUNTER, 32'h00000000);
		wr(tcc_pkg::OFF_MODE, 32'h00000001);
		idle(13);
		wr(tcc_pkg::OFF_MODE, 32'h00000000);
		rd(tcc_pkg::OFF_COUNTER, q);
		check("divided count", q, 32'h00000004);
		wr(tcc_pkg::OFF_CTRL, 32'h00000000);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		levelReq = 4'h0;
		mismatches = 0;
		cmpCount = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		sc_reset();
		sc_compare();
		sc_overflow();
		sc_clear_on_a();
		sc_capture();
		sc_buffered_compare();
		sc_prescale();
		wrap_up();
	end
endmodule
